// ---- rtl/ldb_pkg.sv ----
// shared constants, types and helpers of the local data buffer
package ldb_pkg;
   localparam int HW = 64;
   localparam int AW = 32;
   localparam int PW = 8;
   localparam int CPM_DEPTH = 4;
   localparam int CPP_ENTRIES = 4;
   localparam int CPP_DWS = 4;
   localparam int FIFO_DEPTH = 2;
   localparam logic [HW-1:0] HD_RST = 64'h0000_0000_0000_0000;
   localparam logic [HW-1:0] ABORT_DATA = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [AW-1:0] AD_RST = 32'h0000_0000;
   localparam logic [PW-1:0] PD_RST = 8'h00;
   localparam logic [2:0] CNT_RST = 3'h0;
   localparam logic [1:0] STEP_RST = 2'h0;

   typedef enum logic [1:0] {
      HS_MEMRD = 2'b00,
      HS_PCIASM = 2'b01,
      HS_ABORT = 2'b10
   } ldb_hsrc_t;

   typedef enum logic [3:0] {
      OP_CPU_WR_MEM = 4'h0,
      OP_MEM_POP = 4'h1,
      OP_CPU_WR_PCI = 4'h2,
      OP_CPU_WR_IO = 4'h3,
      OP_CPU_RD_MEM = 4'h4,
      OP_CPU_RD_PCI = 4'h5,
      OP_PCI_WR_MEM = 4'h6,
      OP_PCI_RD_MEM = 4'h7,
      OP_PCI_RD_L2 = 4'h8,
      OP_ABORT = 4'h9
   } ldb_op_t;

   // even parity, one bit per byte lane
   function automatic logic [PW-1:0] ldb_par(input logic [HW-1:0] d);
      logic [PW-1:0] p;
      p = PD_RST;
      for (int i = 0; i < PW; i++) begin
         p[i] = ^d[8*i +: 8];
      end
      return p;
   endfunction
endpackage

// ---- rtl/ldb_if.sv ----
// strobe and status carrier between buffer and controller
`timescale 1ns/100ps
interface ldb_if;
   import ldb_pkg::*;
   logic cmpsh;
   logic cmpop;
   logic cppsh;
   logic cpp_last;
   logic cppop;
   logic mdle;
   logic mdchk;
   logic prdle;
   logic pr_hd;
   logic adle;
   logic dw_hi;
   logic hd_load;
   logic md_load;
   logic ad_push;
   logic ad_take;
   logic hd_drive;
   logic md_drive;
   ldb_hsrc_t hsrc;
   logic cpm_full;
   logic cpm_empty;
   logic cpp_full;
   logic cpp_empty;
   logic ptm_full;
   logic ad_valid;
   logic ad_rdy;
   logic par_err;
   modport dev(
      input cmpsh, cmpop, cppsh, cpp_last, cppop, mdle, mdchk, prdle, pr_hd, adle,
      input dw_hi, hd_load, md_load, ad_push, ad_take, hd_drive, md_drive, hsrc,
      output cpm_full, cpm_empty, cpp_full, cpp_empty, ptm_full, ad_valid, ad_rdy,
      output par_err
   );
   modport ctl(
      output cmpsh, cmpop, cppsh, cpp_last, cppop, mdle, mdchk, prdle, pr_hd, adle,
      output dw_hi, hd_load, md_load, ad_push, ad_take, hd_drive, md_drive, hsrc,
      input cpm_full, cpm_empty, cpp_full, cpp_empty, ptm_full, ad_valid, ad_rdy,
      input par_err
   );
endinterface

// ---- rtl/ldb_fifo2.sv ----
// two-entry valid/ready buffer in the outbound pci data path
`timescale 1ns/100ps
module ldb_fifo2 #(
   parameter int W = ldb_pkg::AW
) (
   input wire logic CLOCK, // clock
   input wire logic RESET_N, // sync reset
   input wire logic in_valid, // word offered
   output logic in_ready, // room for a word
   input wire logic [W-1:0] in_data, // word in
   output logic out_valid, // word held
   input wire logic out_ready, // receiver takes
   output logic [W-1:0] out_data // head word
);
   import ldb_pkg::*;
   logic [W-1:0] mem_q [FIFO_DEPTH];
   logic wp_q;
   logic rp_q;
   logic [1:0] cnt_q;
   logic wr;
   logic rd;

   assign in_ready = (cnt_q != 2'(FIFO_DEPTH));
   assign out_valid = (cnt_q != 2'h0);
   assign out_data = mem_q[rp_q];
   assign wr = in_valid && in_ready;
   assign rd = out_valid && out_ready;

   always_ff @(posedge CLOCK) begin
      if (wr) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'h0;
      end else begin
         wp_q <= wp_q ^ wr;
         rp_q <= rp_q ^ rd;
         cnt_q <= cnt_q + 2'(wr) - 2'(rd);
      end
   end
endmodule

// ---- rtl/ldb_dev.sv ----
// data buffer end: posted write buffers, read buffers and parity
//
// Behaviour
// - cpu-to-pci buffer: four entries, four dwords
// - cpu-to-mem buffer: one line, four quadwords
// - pci-to-mem buffer holds one quadword
// - mem-to-cpu read buffer holds one quadword
// - mem-to-pci read buffer, one quadword, dram or l2
// - moves data among host, memory, pci ports
// - host and pci side logic clocked synchronously
// - every step only on controller strobes
// - cpu memory writes pass the cpu-to-mem buffer
// - memory read data latched for host hold
// - parity checked on cpu memory reads
// - pci writes posted, popped when pci idle
// - full pci write buffer holds off writes
// - io writes buffered but complete after transfer
// - pci read hitting modified l2 uses host data
// - controller waits one state before second dword of a pci read
// - cpu pci read waits for drained buffer
// - pci read data assembled before host drive
// - pci writes posted, also to host on hit
// - parity generated on all memory writes
// - parity ignored on pci memory reads
// - data steered per cycle type, abort data
`timescale 1ns/100ps
module ldb_dev (
   input wire logic CLOCK, // processor clock
   input wire logic RESET_N, // sync reset
   ldb_if.dev BUS, // controller strobes and status
   input wire logic [ldb_pkg::HW-1:0] HD_IN, // host data in
   output logic [ldb_pkg::HW-1:0] HD_OUT, // host data out
   output logic HD_OE_N, // host data enable
   input wire logic [ldb_pkg::HW-1:0] MD_IN, // memory data in
   output logic [ldb_pkg::HW-1:0] MD_OUT, // memory data out
   output logic MD_OE_N, // memory data enable
   input wire logic [ldb_pkg::PW-1:0] PD_IN, // memory parity in
   output logic [ldb_pkg::PW-1:0] PD_OUT, // memory parity out
   input wire logic [ldb_pkg::AW-1:0] AD_IN, // pci data in
   output logic [ldb_pkg::AW-1:0] AD_OUT, // pci data out
   output logic AD_OE_N // pci data enable
);
   import ldb_pkg::*;

   // ----------------------------------------
   // cpu-to-mem line buffer
   // ----------------------------------------
   logic [HW-1:0] cpm_mem_q [CPM_DEPTH];
   logic [1:0] cpm_wp_q;
   logic [1:0] cpm_rp_q;
   logic [2:0] cpm_cnt_q;
   logic cpm_push;
   logic cpm_pop;

   assign BUS.cpm_full = (cpm_cnt_q == 3'(CPM_DEPTH));
   assign BUS.cpm_empty = (cpm_cnt_q == CNT_RST);
   assign cpm_push = BUS.cmpsh && !BUS.cpm_full;
   assign cpm_pop = BUS.cmpop && !BUS.cpm_empty;

   always_ff @(posedge CLOCK) begin
      if (cpm_push) begin
         cpm_mem_q[cpm_wp_q] <= HD_IN;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         cpm_wp_q <= 2'h0;
         cpm_rp_q <= 2'h0;
         cpm_cnt_q <= CNT_RST;
      end else begin
         cpm_wp_q <= cpm_wp_q + 2'(cpm_push);
         cpm_rp_q <= cpm_rp_q + 2'(cpm_pop);
         cpm_cnt_q <= cpm_cnt_q + 3'(cpm_push) - 3'(cpm_pop);
      end
   end

   // ----------------------------------------
   // cpu-to-pci posted write buffer
   // ----------------------------------------
   logic [AW-1:0] cpp_mem_q [CPP_ENTRIES*CPP_DWS];
   logic [2:0] cpp_len_q [CPP_ENTRIES];
   logic [1:0] cpp_wp_q;
   logic [1:0] cpp_rp_q;
   logic [1:0] cpp_fill_q;
   logic [1:0] cpp_pdw_q;
   logic [2:0] cpp_ent_q;
   logic cpp_push;
   logic cpp_close;
   logic cpp_pop;
   logic cpp_free;
   logic fifo_rdy;

   assign BUS.cpp_full = (cpp_ent_q == 3'(CPP_ENTRIES));
   assign BUS.cpp_empty = (cpp_ent_q == CNT_RST);
   assign cpp_push = BUS.cppsh && !BUS.cpp_full;
   assign cpp_close = cpp_push && (BUS.cpp_last || cpp_fill_q == 2'(CPP_DWS-1));
   // explicit pushes take the fifo first; draining just waits a cycle
   assign cpp_pop = BUS.cppop && !BUS.cpp_empty && fifo_rdy && !BUS.ad_push;
   assign cpp_free = cpp_pop && ({1'b0, cpp_pdw_q} + 3'h1 == cpp_len_q[cpp_rp_q]);

   always_ff @(posedge CLOCK) begin
      if (cpp_push) begin
         cpp_mem_q[{cpp_wp_q, cpp_fill_q}] <= BUS.dw_hi ? HD_IN[63:32] : HD_IN[31:0];
      end
      if (cpp_close) begin
         cpp_len_q[cpp_wp_q] <= {1'b0, cpp_fill_q} + 3'h1;
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         cpp_wp_q <= 2'h0;
         cpp_rp_q <= 2'h0;
         cpp_fill_q <= 2'h0;
         cpp_pdw_q <= 2'h0;
         cpp_ent_q <= CNT_RST;
      end else begin
         cpp_wp_q <= cpp_wp_q + 2'(cpp_close);
         cpp_fill_q <= cpp_close ? 2'h0 : cpp_fill_q + 2'(cpp_push);
         cpp_rp_q <= cpp_rp_q + 2'(cpp_free);
         cpp_pdw_q <= cpp_free ? 2'h0 : cpp_pdw_q + 2'(cpp_pop);
         cpp_ent_q <= cpp_ent_q + 3'(cpp_close) - 3'(cpp_free);
      end
   end

   // ----------------------------------------
   // read buffers and pci-to-mem buffer
   // ----------------------------------------
   logic [HW-1:0] mem_to_cpu_read_buffer_q;
   logic [HW-1:0] mem_to_pci_read_buffer_q;
   logic [HW-1:0] ptm_q;
   logic [1:0] ptm_v_q;
   logic par_err_q;
   logic ptm_clr;

   always_ff @(posedge CLOCK) begin
      if (BUS.mdle) begin
         mem_to_cpu_read_buffer_q <= MD_IN;
      end
      if (BUS.prdle) begin
         mem_to_pci_read_buffer_q <= BUS.pr_hd ? HD_IN : MD_IN;
      end
      if (BUS.adle && BUS.dw_hi) begin
         ptm_q[63:32] <= AD_IN;
      end
      if (BUS.adle && !BUS.dw_hi) begin
         ptm_q[31:0] <= AD_IN;
      end
   end

   assign ptm_clr = BUS.md_load || (BUS.hd_load && BUS.hsrc == HS_PCIASM);
   assign BUS.ptm_full = &ptm_v_q;

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         ptm_v_q <= 2'h0;
      end else begin
         // a latch in the same cycle as the clear survives
         for (int i = 0; i < 2; i++) begin
            if (BUS.adle && BUS.dw_hi == 1'(i)) begin
               ptm_v_q[i] <= 1'b1;
            end else if (ptm_clr) begin
               ptm_v_q[i] <= 1'b0;
            end
         end
      end
   end

   // mem_to_pci_read_buffer latches skip the check: pci reads ignore parity
   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         par_err_q <= 1'b0;
      end else begin
         par_err_q <= BUS.mdle && BUS.mdchk && (ldb_par(MD_IN) != PD_IN);
      end
   end
   assign BUS.par_err = par_err_q;

   // ----------------------------------------
   // host and memory drivers
   // ----------------------------------------
   logic [HW-1:0] hd_q;
   logic [HW-1:0] md_q;
   logic [PW-1:0] pd_q;

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         hd_q <= HD_RST;
      end else if (BUS.hd_load) begin
         case (BUS.hsrc)
            HS_MEMRD: hd_q <= mem_to_cpu_read_buffer_q;
            HS_PCIASM: hd_q <= ptm_q;
            default: hd_q <= ABORT_DATA;
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         md_q <= HD_RST;
         pd_q <= PD_RST;
      end else if (cpm_pop) begin
         md_q <= cpm_mem_q[cpm_rp_q];
         pd_q <= ldb_par(cpm_mem_q[cpm_rp_q]);
      end else if (BUS.md_load) begin
         md_q <= ptm_q;
         pd_q <= ldb_par(ptm_q);
      end
   end

   assign HD_OUT = hd_q;
   assign HD_OE_N = !BUS.hd_drive;
   assign MD_OUT = md_q;
   assign PD_OUT = pd_q;
   assign MD_OE_N = !BUS.md_drive;

   // ----------------------------------------
   // outbound pci path
   // ----------------------------------------
   logic fifo_in_v;
   logic [AW-1:0] fifo_in_d;

   // single clock: the pci side is stepped by the controller's strobes
   assign fifo_in_v = BUS.ad_push || cpp_pop;
   assign fifo_in_d = BUS.ad_push ? (BUS.dw_hi ? mem_to_pci_read_buffer_q[63:32] : mem_to_pci_read_buffer_q[31:0])
                                  : cpp_mem_q[{cpp_rp_q, cpp_pdw_q}];
   assign BUS.ad_rdy = fifo_rdy;

   ldb_fifo2 #(.W(AW)) u_fifo (
      .CLOCK(CLOCK),
      .RESET_N(RESET_N),
      .in_valid(fifo_in_v),
      .in_ready(fifo_rdy),
      .in_data(fifo_in_d),
      .out_valid(BUS.ad_valid),
      .out_ready(BUS.ad_take),
      .out_data(AD_OUT)
   );

   assign AD_OE_N = !BUS.ad_valid;
endmodule

// ---- rtl/ldb_ctl.sv ----
// controller end: sequences buffer strobes per host command
`timescale 1ns/100ps
module ldb_ctl (
   input wire logic CLOCK, // processor clock
   input wire logic RESET_N, // sync reset
   ldb_if.ctl BUS, // strobes to the buffer
   input wire logic CMD_VALID, // command offered
   input wire ldb_pkg::ldb_op_t CMD_OP, // cycle type
   input wire logic CMD_HI, // upper dword select
   input wire logic CMD_LAST, // closes a pci entry
   input wire logic CMD_HIT, // pci write hits l2
   output logic CMD_READY, // command taken
   output logic DONE, // cycle finished, pulse
   input wire logic AD_TAKE, // pci receiver takes
   output logic PAR_ERR // parity error, pulse
);
   import ldb_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAITE = 2'b01,
      ST_RUN = 2'b10
   } ldb_st_t;

   ldb_st_t st_q;
   ldb_op_t op_q;
   logic [1:0] step_q;
   logic hi_q;
   logic last_q;
   logic hit_q;
   logic take;
   logic fin;
   logic hold;
   logic drained;

   assign drained = BUS.cpp_empty && !BUS.ad_valid;
   // hold-off terms keep the host stalled, not the buffer
   assign CMD_READY = (st_q == ST_IDLE)
      && !((CMD_OP == OP_CPU_WR_PCI || CMD_OP == OP_CPU_WR_IO) && BUS.cpp_full)
      && !(CMD_OP == OP_CPU_WR_MEM && BUS.cpm_full);
   assign take = CMD_VALID && CMD_READY;

   always_comb begin
      BUS.cmpsh = 1'b0;
      BUS.cmpop = 1'b0;
      BUS.cppsh = 1'b0;
      BUS.cpp_last = last_q;
      BUS.mdle = 1'b0;
      BUS.mdchk = 1'b0;
      BUS.prdle = 1'b0;
      BUS.pr_hd = (op_q == OP_PCI_RD_L2);
      BUS.adle = 1'b0;
      BUS.dw_hi = hi_q;
      BUS.hd_load = 1'b0;
      BUS.md_load = 1'b0;
      BUS.ad_push = 1'b0;
      BUS.hd_drive = 1'b0;
      BUS.md_drive = 1'b0;
      BUS.hsrc = HS_MEMRD;
      fin = 1'b0;
      hold = 1'b0;
      if (st_q == ST_RUN) begin
         case (op_q)
            OP_CPU_WR_MEM: begin
               BUS.cmpsh = 1'b1;
               fin = 1'b1;
            end
            OP_MEM_POP: begin
               BUS.cmpop = (step_q == 2'h0);
               BUS.md_drive = (step_q == 2'h1);
               fin = (step_q == 2'h1);
            end
            OP_CPU_WR_PCI, OP_CPU_WR_IO: begin
               BUS.cppsh = 1'b1;
               fin = (op_q == OP_CPU_WR_PCI);
            end
            OP_CPU_RD_MEM: begin
               BUS.mdle = (step_q == 2'h0);
               BUS.mdchk = 1'b1;
               BUS.hd_load = (step_q == 2'h1);
               BUS.hd_drive = (step_q == 2'h2);
               fin = (step_q == 2'h2);
            end
            OP_CPU_RD_PCI, OP_PCI_WR_MEM: begin
               BUS.adle = (step_q[1] == 1'b0);
               BUS.dw_hi = step_q[0];
               BUS.hsrc = HS_PCIASM;
               BUS.md_load = (step_q == 2'h2) && (op_q == OP_PCI_WR_MEM);
               BUS.md_drive = (step_q == 2'h3) && (op_q == OP_PCI_WR_MEM);
               BUS.hd_load = (step_q == 2'h2) && (op_q == OP_CPU_RD_PCI || hit_q);
               BUS.hd_drive = (step_q == 2'h3) && (op_q == OP_CPU_RD_PCI || hit_q);
               fin = (step_q == 2'h3);
            end
            OP_PCI_RD_MEM, OP_PCI_RD_L2: begin
               BUS.prdle = (step_q == 2'h0);
               BUS.ad_push = step_q[0] && BUS.ad_rdy;
               BUS.dw_hi = step_q[1];
               hold = step_q[0] && !BUS.ad_rdy;
               fin = (step_q == 2'h3) && BUS.ad_rdy;
            end
            default: begin
               BUS.hsrc = HS_ABORT;
               BUS.hd_load = (step_q == 2'h0);
               BUS.hd_drive = (step_q == 2'h1);
               fin = (step_q == 2'h1);
            end
         endcase
      end
   end

   // posted pci writes drain whenever no cycle is in ST_RUN (idle or waiting)
   assign BUS.cppop = (st_q != ST_RUN) && !BUS.cpp_empty;
   assign BUS.ad_take = AD_TAKE;
   assign DONE = fin || (st_q == ST_WAITE && op_q == OP_CPU_WR_IO && drained);
   assign PAR_ERR = BUS.par_err;

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         st_q <= ST_IDLE;
         step_q <= STEP_RST;
      end else begin
         case (st_q)
            ST_IDLE: begin
               if (take) begin
                  st_q <= (CMD_OP == OP_CPU_RD_PCI) ? ST_WAITE : ST_RUN;
                  step_q <= STEP_RST;
               end
            end
            ST_WAITE: begin
               if (drained) begin
                  st_q <= (op_q == OP_CPU_WR_IO) ? ST_IDLE : ST_RUN;
               end
            end
            default: begin
               if (fin) begin
                  st_q <= ST_IDLE;
               end else if (op_q == OP_CPU_WR_IO) begin
                  st_q <= ST_WAITE;
               end else if (!hold) begin
                  step_q <= step_q + 2'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLOCK) begin
      if (!RESET_N) begin
         op_q <= OP_CPU_WR_MEM;
         hi_q <= 1'b0;
         last_q <= 1'b0;
         hit_q <= 1'b0;
      end else if (take) begin
         op_q <= CMD_OP;
         hi_q <= CMD_HI;
         last_q <= CMD_LAST || (CMD_OP == OP_CPU_WR_IO);
         hit_q <= CMD_HIT;
      end
   end
endmodule

// ---- bench/ldb_asserts.sv ----
// concurrent checks on the strobe and status carrier between the two ends
`timescale 1ns/100ps
module ldb_asserts (
   input wire logic CLOCK, // clock
   input wire logic RESET_N, // sync reset
   input wire logic cmpsh, // mem buffer push
   input wire logic cmpop, // mem buffer pop
   input wire logic cppsh, // pci buffer push
   input wire logic cppop, // pci buffer pop
   input wire logic mdle, // mem read latch
   input wire logic mdchk, // parity check
   input wire logic prdle, // pci read latch
   input wire logic adle, // pci data latch
   input wire logic dw_hi, // upper dword
   input wire logic hd_load, // host data load
   input wire logic md_load, // mem data load
   input wire logic ad_push, // fifo push
   input wire logic hd_drive, // host enable
   input wire logic md_drive, // mem enable
   input wire ldb_pkg::ldb_hsrc_t hsrc, // host source
   input wire logic cpm_full, // mem buffer full
   input wire logic cpm_empty, // mem buffer empty
   input wire logic cpp_full, // pci buffer full
   input wire logic cpp_empty, // pci buffer empty
   input wire logic ad_rdy, // fifo room
   input wire logic par_err // parity error
);
   import ldb_pkg::*;
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESET_N);
   // ---------------------------------------------
   // buffer occupancy
   // ---------------------------------------------
   a_cpm_push_room: assert property (cmpsh |-> !cpm_full)
      else $error("push into full memory write buffer");
   a_cpm_pop_data: assert property (cmpop |-> !cpm_empty)
      else $error("pop from empty memory write buffer");
   a_cpp_push_room: assert property (cppsh |-> !cpp_full)
      else $error("push into full pci write buffer");
   a_cpp_pop_data: assert property (cppop |-> !cpp_empty)
      else $error("pop from empty pci write buffer");
   a_flags_excl: assert property (!(cpp_full && cpp_empty) && !(cpm_full && cpm_empty))
      else $error("buffer shows full and empty together");
   a_push_room: assert property (ad_push |-> ad_rdy)
      else $error("word pushed into full output fifo");
   // ---------------------------------------------
   // transfer sequencing
   // ---------------------------------------------
   a_mem_drive: assert property ((cmpop || md_load) |=> md_drive)
      else $error("memory write not driven after load");
   a_mem_read_seq: assert property (mdle && mdchk |=> hd_load && hsrc == HS_MEMRD ##1 hd_drive)
      else $error("memory read not loaded and driven in order");
   a_par_cause: assert property (par_err |-> $past(mdchk))
      else $error("parity error without a checked read");
   a_dword_wait: assert property (ad_push && !dw_hi |=> !ad_push)
      else $error("no wait state before second dword");
   a_prd_push: assert property (prdle |=> ##[0:40] (ad_push && !dw_hi))
      else $error("read buffer never forwarded");
   a_adle_pair: assert property (adle && !dw_hi |=> adle && dw_hi)
      else $error("upper pci dword not latched after lower");
   a_host_pulse: assert property (hd_drive |=> !hd_drive)
      else $error("host drive longer than one cycle");
endmodule

// ---- bench/host_memory_pci_data_buffer_tb_top.sv ----
// self-checking bench joining both ends through the carrier
`timescale 1ns/100ps
module host_memory_pci_data_buffer_tb_top;
   import ldb_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cmd_valid = 1'b0;
   ldb_op_t cmd_op = OP_CPU_WR_MEM;
   logic cmd_hi = 1'b0, cmd_last = 1'b0, cmd_hit = 1'b0, ad_take = 1'b0, lo_seen = 1'b0;
   logic [HW-1:0] hd_in = 64'h0, md_in = 64'h0, hd_out, md_out;
   logic [PW-1:0] pd_in = 8'h00, pd_out;
   logic [AW-1:0] ad_in = 32'h0, ad_next = 32'h0, ad_out;
   logic hd_oe_n, md_oe_n, ad_oe_n, cmd_ready, done, par_err;
   int err_count = 0, checks = 0, cyc = 0, perr = 0, lat, p0;
   ldb_if i_ldb_if();
   always #2 clk = ~clk;
   ldb_dev i_ldb_dev (.CLOCK(clk), .RESET_N(rst_n), .BUS(i_ldb_if.dev), .HD_IN(hd_in),
      .HD_OUT(hd_out), .HD_OE_N(hd_oe_n), .MD_IN(md_in), .MD_OUT(md_out), .MD_OE_N(md_oe_n),
      .PD_IN(pd_in), .PD_OUT(pd_out), .AD_IN(ad_in), .AD_OUT(ad_out), .AD_OE_N(ad_oe_n));
   ldb_ctl i_ldb_ctl (.CLOCK(clk), .RESET_N(rst_n), .BUS(i_ldb_if.ctl), .CMD_VALID(cmd_valid),
      .CMD_OP(cmd_op), .CMD_HI(cmd_hi), .CMD_LAST(cmd_last), .CMD_HIT(cmd_hit),
      .CMD_READY(cmd_ready), .DONE(done), .AD_TAKE(ad_take), .PAR_ERR(par_err));
   ldb_asserts i_ldb_asserts (.CLOCK(clk), .RESET_N(rst_n), .cmpsh(i_ldb_if.cmpsh),
      .cmpop(i_ldb_if.cmpop), .cppsh(i_ldb_if.cppsh), .cppop(i_ldb_if.cppop),
      .mdle(i_ldb_if.mdle), .mdchk(i_ldb_if.mdchk), .prdle(i_ldb_if.prdle),
      .adle(i_ldb_if.adle), .dw_hi(i_ldb_if.dw_hi), .hd_load(i_ldb_if.hd_load),
      .md_load(i_ldb_if.md_load), .ad_push(i_ldb_if.ad_push), .hd_drive(i_ldb_if.hd_drive),
      .md_drive(i_ldb_if.md_drive), .hsrc(i_ldb_if.hsrc), .cpm_full(i_ldb_if.cpm_full),
      .cpm_empty(i_ldb_if.cpm_empty), .cpp_full(i_ldb_if.cpp_full),
      .cpp_empty(i_ldb_if.cpp_empty), .ad_rdy(i_ldb_if.ad_rdy), .par_err(i_ldb_if.par_err));
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [HW-1:0] q(input logic [7:0] s);
      return {s, 8'h3C, ~s, 8'h81, s ^ 8'h5A, 8'h7E, s + 8'h11, 8'hC3};
   endfunction
   function automatic logic [PW-1:0] bpar(input logic [HW-1:0] d);
      logic [PW-1:0] p;
      p = 8'h00;
      for (int i = 0; i < PW; i++) begin
         p[i] = ^d[8*i +: 8];
      end
      return p;
   endfunction
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic put(input logic [HW-1:0] hd, md, input logic [PW-1:0] pd,
         input logic [AW-1:0] lo, hi);
      @(posedge clk);
      hd_in <= hd;
      md_in <= md;
      pd_in <= pd;
      ad_in <= lo;
      ad_next <= hi;
   endtask
   // offer a command, l is -1 when refused, else cycles from take to done
   task automatic run(input ldb_op_t op, input logic hi, last, hit, input int lim, output int l);
      int n;
      logic ok;
      n = 0;
      l = -1;
      @(posedge clk);
      cmd_op <= op;
      cmd_hi <= hi;
      cmd_last <= last;
      cmd_hit <= hit;
      cmd_valid <= 1'b1;
      @(negedge clk);
      while (cmd_ready !== 1'b1 && n < lim) begin
         @(negedge clk);
         n++;
      end
      ok = (cmd_ready === 1'b1);
      @(posedge clk);
      cmd_valid <= 1'b0;
      if (ok) begin
         l = 0;
         @(negedge clk);
         while (done !== 1'b1 && l < 300) begin
            @(negedge clk);
            l++;
         end
      end
   endtask
   task automatic take(input logic [AW-1:0] exp);
      int n;
      n = 0;
      @(negedge clk);
      while (ad_oe_n !== 1'b0 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk("ad_out", {32'h0, exp}, {32'h0, ad_out});
      @(posedge clk);
      ad_take <= 1'b1;
      @(posedge clk);
      ad_take <= 1'b0;
   endtask
   // pci target model: upper dword follows once the lower one was latched
   always @(negedge clk) lo_seen = i_ldb_if.adle && !i_ldb_if.dw_hi;
   always @(posedge clk) begin
      if (lo_seen) begin
         ad_in <= ad_next;
      end
   end
   always @(negedge clk) begin
      if (par_err === 1'b1) begin
         perr++;
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         close_out();
      end
   end
   // ---------------------------------------------
   // tests
   // ---------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      chk("enables", 64'h7, {hd_oe_n, md_oe_n, ad_oe_n});
      chk("ready done", 64'h2, {cmd_ready, done});
      chk("outputs", 64'h0, hd_out | md_out);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         put(q(8'(i)), 64'h0, 8'h00, 32'h0, 32'h0);
         run(OP_CPU_WR_MEM, 1'b0, 1'b0, 1'b0, 50, lat);
         chk("wr_mem lat", 0, lat);
      end
      run(OP_CPU_WR_MEM, 1'b0, 1'b0, 1'b0, 5, lat);
      chk("cpm_full", 1, i_ldb_if.cpm_full);
      chk("wr_mem refused", -1, lat);
      for (int i = 0; i < 4; i++) begin
         run(OP_MEM_POP, 1'b0, 1'b0, 1'b0, 50, lat);
         chk("pop lat", 1, lat);
         chk("md_oe_n", 0, md_oe_n);
         chk("md_out", q(8'(i)), md_out);
         chk("pd_out", bpar(q(8'(i))), pd_out);
      end
      chk("cpm_empty", 1, i_ldb_if.cpm_empty);
      $display("test cpu_mem done");
      for (int e = 0; e < 2; e++) begin
         put(64'h0, q(8'h40 + 8'(e)), bpar(q(8'h40 + 8'(e))) ^ 8'(e), 32'h0, 32'h0);
         p0 = perr;
         run(OP_CPU_RD_MEM, 1'b0, 1'b0, 1'b0, 50, lat);
         chk("rd_mem lat", 2, lat);
         chk("hd_oe_n", 0, hd_oe_n);
         chk("hd_out", q(8'h40 + 8'(e)), hd_out);
         chk("par errors", e, perr - p0);
         put(64'h0, 64'h0, 8'h00, 32'h0, 32'h0);
         @(negedge clk);
         chk("hd_out hold", q(8'h40 + 8'(e)), hd_out);
      end
      $display("test cpu_read done");
      put(q(8'h77), q(8'h66), ~bpar(q(8'h66)), 32'h0, 32'h0);
      p0 = perr;
      run(OP_PCI_RD_MEM, 1'b0, 1'b0, 1'b0, 50, lat);
      chk("pci_rd lat", 3, lat);
      chk("par ignored", 0, perr - p0);
      fork
         run(OP_PCI_RD_L2, 1'b0, 1'b0, 1'b0, 50, lat);
         begin
            repeat (8) @(posedge clk);
            take(q(8'h66));
            take(q(8'h66) >> 32);
            take(q(8'h77));
            take(q(8'h77) >> 32);
         end
      join
      chk("stalled read", 1, lat > 3);
      @(negedge clk);
      chk("fifo empty", 1, ad_oe_n);
      $display("test pci_read done");
      for (int i = 0; i < 6; i++) begin
         put(q(8'h90 + 8'(i)), 64'h0, 8'h00, 32'h0, 32'h0);
         run(OP_CPU_WR_PCI, 1'(i), 1'b1, 1'b0, 50, lat);
         chk("wr_pci lat", 0, lat);
      end
      run(OP_CPU_WR_PCI, 1'b0, 1'b1, 1'b0, 5, lat);
      chk("cpp_full", 1, i_ldb_if.cpp_full);
      chk("wr_pci refused", -1, lat);
      put(64'h0, 64'h0, 8'h00, 32'h1234_5678, 32'h9ABC_DEF0);
      fork
         run(OP_CPU_RD_PCI, 1'b0, 1'b0, 1'b0, 50, lat);
         begin
            repeat (20) @(posedge clk);
            for (int i = 0; i < 6; i++) begin
               take(q(8'h90 + 8'(i)) >> (32 * (i % 2)));
            end
         end
      join
      chk("drain first", 1, lat > 20);
      chk("hd_oe_n", 0, hd_oe_n);
      chk("assembled", 64'h9ABC_DEF0_1234_5678, hd_out);
      $display("test cpu_pci done");
      put(q(8'hB4), 64'h0, 8'h00, 32'h0, 32'h0);
      fork
         run(OP_CPU_WR_IO, 1'b1, 1'b1, 1'b0, 50, lat);
         begin
            repeat (12) @(posedge clk);
            take(q(8'hB4) >> 32);
         end
      join
      chk("io wait", 1, lat >= 10);
      $display("test io_write done");
      for (int h = 0; h < 2; h++) begin
         put(64'h0, 64'h0, 8'h00, 32'h0F1E_2D3C + 32'(h), 32'h4B5A_6978 ^ 32'(h));
         run(OP_PCI_WR_MEM, 1'b0, 1'b0, 1'(h), 50, lat);
         chk("pci_wr lat", 3, lat);
         chk("md_oe_n", 0, md_oe_n);
         chk("md_out", {32'h4B5A_6978 ^ 32'(h), 32'h0F1E_2D3C + 32'(h)}, md_out);
         chk("pd_out", bpar(md_out), pd_out);
         if (h == 1) begin
            chk("hit host", md_out, hd_out);
         end
      end
      run(OP_ABORT, 1'b0, 1'b0, 1'b0, 50, lat);
      chk("abort lat", 1, lat);
      chk("abort oe", 0, hd_oe_n);
      chk("abort data", ABORT_DATA, hd_out);
      $display("test pci_write done");
      close_out();
   end
endmodule
